// File: rtl/sarh_consts.vh
// Constants of the converter host controller.
`ifndef SARH_CONSTS_VH
`define SARH_CONSTS_VH
// Timing figures in ns and the core clock period in ns.
`define SARH_CLK_PERIOD_NS   5
`define SARH_T_CONV_MAX_NS   1400
`define SARH_T_CONV_MIN_NS   500
`define SARH_T_HIGH_NS       10
`define SARH_T_LOW_NS        20
`define SARH_T_SETUP_NS      5
`define SARH_T_SCLK_HALF_NS  15
// Cycle counts: all round up except the minimum conversion time, which rounds down.
`define SARH_CONV_MAX_CYC ((`SARH_T_CONV_MAX_NS + `SARH_CLK_PERIOD_NS - 1) / `SARH_CLK_PERIOD_NS)
`define SARH_CONV_MIN_CYC (`SARH_T_CONV_MIN_NS / `SARH_CLK_PERIOD_NS)
`define SARH_HIGH_CYC ((`SARH_T_HIGH_NS + `SARH_CLK_PERIOD_NS - 1) / `SARH_CLK_PERIOD_NS)
`define SARH_LOW_CYC ((`SARH_T_LOW_NS + `SARH_CLK_PERIOD_NS - 1) / `SARH_CLK_PERIOD_NS)
`define SARH_SETUP_CYC ((`SARH_T_SETUP_NS + `SARH_CLK_PERIOD_NS - 1) / `SARH_CLK_PERIOD_NS)
`define SARH_HALF_CYC ((`SARH_T_SCLK_HALF_NS + `SARH_CLK_PERIOD_NS - 1) / `SARH_CLK_PERIOD_NS)
// Result format.
`define SARH_RESULT_BITS     16
`define SARH_FULL_CODE       16'hFFFF
`define SARH_MID_CODE        16'h8000
`define SARH_ZERO_CODE       16'h0000
// Mode field of the command: bit 0 busy bit, bit 1 4-wire.
`define SARH_MODE_BUSY_BIT   0
`define SARH_MODE_FOUR_BIT   1
`endif

// File: rtl/sarh_sync.v
// Three-stage synchroniser for one pin input.
`timescale 1ns/10ps
`default_nettype none
module sarh_sync
(
  input  wire core_clk,
  input  wire rst,
  input  wire pin_in,
  output reg  level_reg
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // A change counts once the second and third stages agree.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end
  end
endmodule // sarh_sync
`default_nettype wire

// File: rtl/sarh_fifo.v
// Result FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module sarh_fifo
#(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  input  wire             core_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  always @(posedge core_clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // sarh_fifo
`default_nettype wire

// File: rtl/sarh_host.v
// Host controller that runs conversions and reads results serially.
`timescale 1ns/10ps
`default_nettype none
`include "sarh_consts.vh"
module sarh_host
#(
  parameter RESULT_BITS = `SARH_RESULT_BITS,
  parameter FIFO_DEPTH  = 8
)
(
  input  wire                   core_clk,
  input  wire                   rst,
  input  wire                   start_req,
  input  wire [1:0]             start_mode,
  output wire                   start_ready,
  output wire [RESULT_BITS-1:0] result_data,
  output wire                   result_valid,
  input  wire                   result_ready,
  output reg                    busy_seen_reg,
  output wire                   conversion_start_pin,
  output wire                   serial_input_pin,
  output wire                   sclk_pin,
  input  wire                   serial_output_pin
);
  // ****************************************************************
  // Constants and states
  // ****************************************************************
  localparam [3:0] ST_IDLE   = 4'd0;
  localparam [3:0] ST_SETUP  = 4'd1;
  localparam [3:0] ST_HIGH   = 4'd2;
  localparam [3:0] ST_CONV   = 4'd3;
  localparam [3:0] ST_SEL    = 4'd4;
  localparam [3:0] ST_FIRST  = 4'd5;
  localparam [3:0] ST_CLK_HI = 4'd6;
  localparam [3:0] ST_CLK_LO = 4'd7;
  localparam [3:0] ST_PUSH   = 4'd8;
  localparam [3:0] ST_GAP    = 4'd9;
  localparam [11:0] CONV_MAX = `SARH_CONV_MAX_CYC;
  localparam [11:0] CONV_MIN = `SARH_CONV_MIN_CYC;
  localparam [11:0] HIGH_CYC = `SARH_HIGH_CYC;
  localparam [11:0] LOW_CYC  = `SARH_LOW_CYC;
  localparam [11:0] SET_CYC  = `SARH_SETUP_CYC;
  localparam [11:0] HALF_CYC = `SARH_HALF_CYC;
  // Three synchroniser stages: first sample waits this many half periods.
  localparam [11:0] SAMPLE_LAG = 12'h0004;

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [3:0]             state_reg;
  reg [3:0]             state_next;
  reg [11:0]            timer_reg;
  reg [11:0]            timer_next;
  reg [4:0]             bit_cnt_reg;
  reg [4:0]             bit_cnt_next;
  reg [RESULT_BITS-1:0] shift_reg;
  reg [RESULT_BITS-1:0] shift_next;
  reg                   busy_mode_reg;
  reg                   busy_mode_next;
  reg                   four_wire_reg;
  reg                   four_wire_next;
  reg                   push_reg;
  reg                   push_next;
  reg                   busy_seen_next;
  reg                   start_pin_reg;
  reg                   start_pin_next;
  reg                   select_pin_reg;
  reg                   select_pin_next;
  reg                   sclk_reg;
  reg                   sclk_next;
  wire                  sdo_level;
  wire                  fifo_in_ready;
  wire [4:0]            total_bits;

  sarh_sync u_sdo_sync
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .pin_in    (serial_output_pin),
    .level_reg (sdo_level)
  );

  sarh_fifo
  #(
    .WIDTH (RESULT_BITS),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  )
  u_fifo
  (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (shift_reg),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (result_data),
    .out_valid (result_valid),
    .out_ready (result_ready)
  );

  // A new conversion is only taken while the FIFO has room, so back-pressure stalls starts.
  assign start_ready = (state_reg == ST_IDLE) && fifo_in_ready;
  // Busy bit adds one leading bit and one falling edge.
  assign total_bits  = busy_mode_reg ? 5'd17 : 5'd16;

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  // Pins come straight from flip-flops so they never glitch between states.
  assign conversion_start_pin = start_pin_reg;
  assign serial_input_pin     = select_pin_reg;
  assign sclk_pin             = sclk_reg;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @*
  begin
    state_next      = state_reg;
    timer_next      = timer_reg;
    bit_cnt_next    = bit_cnt_reg;
    shift_next      = shift_reg;
    busy_mode_next  = busy_mode_reg;
    four_wire_next  = four_wire_reg;
    push_next       = 1'b0;
    busy_seen_next  = busy_seen_reg;
    start_pin_next  = start_pin_reg;
    select_pin_next = select_pin_reg;
    sclk_next       = sclk_reg;
    case (state_reg)
      ST_IDLE:
      begin
        sclk_next = 1'b0;
        if (start_req && fifo_in_ready)
        begin
          busy_mode_next  = start_mode[`SARH_MODE_BUSY_BIT];
          four_wire_next  = start_mode[`SARH_MODE_FOUR_BIT];
          // Start pin goes low first so its rise can begin the conversion.
          start_pin_next  = 1'b0;
          select_pin_next = 1'b1;
          timer_next      = LOW_CYC;
          state_next      = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        // Select pin is held high here, so start low never meets select low.
        if (timer_reg <= SET_CYC)
        begin
          start_pin_next = 1'b1;
          timer_next     = HIGH_CYC;
          state_next     = ST_HIGH;
        end
        else
          timer_next = timer_reg - 1'b1;
      end
      ST_HIGH:
      begin
        if (timer_reg <= 12'h001)
        begin
          // Busy request: 3-wire lowers start, 4-wire lowers select, before minimum time.
          if (busy_mode_reg && !four_wire_reg)
            start_pin_next = 1'b0;
          else if (busy_mode_reg)
            select_pin_next = 1'b0;
          timer_next = CONV_MAX;
          state_next = ST_CONV;
        end
        else
          timer_next = timer_reg - 1'b1;
      end
      ST_CONV:
      begin
        // Wait past the maximum conversion time, clock stopped, level held.
        if (timer_reg <= 12'h001)
        begin
          bit_cnt_next = 5'd0;
          if (busy_mode_reg)
          begin
            timer_next = SAMPLE_LAG * HALF_CYC;
            state_next = ST_FIRST;
          end
          else
          begin
            timer_next = LOW_CYC;
            state_next = ST_SEL;
          end
        end
        else
          timer_next = timer_reg - 1'b1;
      end
      ST_SEL:
      begin
        // No busy bit: the selecting falling edge presents the MSB.
        if (four_wire_reg)
          select_pin_next = 1'b0;
        else
          start_pin_next = 1'b0;
        timer_next = SAMPLE_LAG * HALF_CYC;
        state_next = ST_FIRST;
      end
      ST_FIRST:
      begin
        // Let the first bit settle through the synchroniser before sampling.
        if (timer_reg <= 12'h001)
        begin
          shift_next     = {shift_reg[RESULT_BITS-2:0], sdo_level};
          bit_cnt_next   = 5'd1;
          // A frame without a busy bit clears the flag, so it reports the last frame.
          busy_seen_next = busy_mode_reg & ~sdo_level;
          sclk_next      = 1'b1;
          timer_next     = HALF_CYC;
          state_next     = ST_CLK_HI;
        end
        else
          timer_next = timer_reg - 1'b1;
      end
      ST_CLK_HI:
      begin
        if (timer_reg <= 12'h001)
        begin
          // Falling edge: device shifts the next lower bit out.
          sclk_next  = 1'b0;
          timer_next = SAMPLE_LAG * HALF_CYC;
          if (bit_cnt_reg == total_bits)
            state_next = ST_PUSH;
          else
            state_next = ST_CLK_LO;
        end
        else
          timer_next = timer_reg - 1'b1;
      end
      ST_CLK_LO:
      begin
        if (timer_reg <= 12'h001)
        begin
          // The busy bit is dropped out of the word by shifting past it.
          shift_next   = {shift_reg[RESULT_BITS-2:0], sdo_level};
          bit_cnt_next = bit_cnt_reg + 1'b1;
          sclk_next    = 1'b1;
          timer_next   = HALF_CYC;
          state_next   = ST_CLK_HI;
        end
        else
          timer_next = timer_reg - 1'b1;
      end
      ST_PUSH:
      begin
        // Releasing start or select floats the device output.
        start_pin_next  = 1'b1;
        select_pin_next = 1'b1;
        push_next       = 1'b1;
        // In 3-wire modes this rise starts a new conversion, so it is waited out.
        if (four_wire_reg)
          timer_next = LOW_CYC;
        else
          timer_next = CONV_MAX;
        state_next      = ST_GAP;
      end
      ST_GAP:
      begin
        if (timer_reg <= 12'h001)
          state_next = ST_IDLE;
        else
          timer_next = timer_reg - 1'b1;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg      <= ST_IDLE;
      timer_reg      <= 12'h000;
      bit_cnt_reg    <= 5'd0;
      shift_reg      <= {RESULT_BITS{1'b0}};
      busy_mode_reg  <= 1'b0;
      four_wire_reg  <= 1'b0;
      push_reg       <= 1'b0;
      busy_seen_reg  <= 1'b0;
      start_pin_reg  <= 1'b1;
      select_pin_reg <= 1'b1;
      sclk_reg       <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      timer_reg      <= timer_next;
      bit_cnt_reg    <= bit_cnt_next;
      shift_reg      <= shift_next;
      busy_mode_reg  <= busy_mode_next;
      four_wire_reg  <= four_wire_next;
      push_reg       <= push_next;
      busy_seen_reg  <= busy_seen_next;
      start_pin_reg  <= start_pin_next;
      select_pin_reg <= select_pin_next;
      sclk_reg       <= sclk_next;
    end
  end
endmodule // sarh_host
`default_nettype wire

// File: verification/sarh_host_asserts.sv
// Checker of the pin sequencing driven by the converter host.
`timescale 1ns/10ps
`default_nettype none
module sarh_host_asserts
#(
  parameter RESULT_BITS = 16
)
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       start_req,
  input wire logic [1:0] start_mode,
  input wire logic       start_ready,
  input wire logic       conversion_start_pin,
  input wire logic       serial_input_pin,
  input wire logic       sclk_pin
);
  // ********
  // Frame tracking.
  // ********
  logic [8:0] cnt_reg;
  logic [4:0] fall_reg;
  logic [1:0] mode_reg;
  logic       act_reg;
  logic       cv_reg;
  logic       st_reg;
  logic       sk_reg;
  logic       cs_reg;
  wire logic       cs_n;
  wire logic       fall;
  wire logic       done;
  wire logic [5:0] total;
  assign cs_n  = conversion_start_pin & serial_input_pin;
  assign fall  = sk_reg & ~sclk_pin;
  assign total = {1'b0, fall_reg} + {5'h00, fall};
  assign done  = cs_n & ~cs_reg & (total != 6'h00);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg  <= 9'h12C;
      fall_reg <= 5'h00;
      mode_reg <= 2'h0;
      act_reg  <= 1'b0;
      cv_reg   <= 1'b0;
      st_reg   <= 1'b1;
      sk_reg   <= 1'b0;
      cs_reg   <= 1'b1;
    end
    else
    begin
      st_reg   <= conversion_start_pin;
      sk_reg   <= sclk_pin;
      cs_reg   <= cs_n;
      fall_reg <= cs_n ? 5'h00 : total[4:0];
      if (start_req & start_ready)
      begin
        mode_reg <= start_mode;
        act_reg  <= 1'b1;
        cv_reg   <= 1'b0;
        cnt_reg  <= 9'h12C;
      end
      else
      begin
        if (done)
          act_reg <= 1'b0;
        if (conversion_start_pin & ~st_reg)
        begin
          cv_reg  <= 1'b1;
          cnt_reg <= 9'h001;
        end
        else if (cnt_reg < 9'h12C)
          cnt_reg <= cnt_reg + 9'h001;
      end
    end
  end
  // ********
  // Properties.
  // ********
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_never_both_low: assert property (conversion_start_pin | serial_input_pin)
    else $error("start and select low together");
  a_select_at_rise: assert property ($rose(conversion_start_pin) |-> serial_input_pin && $past(serial_input_pin))
    else $error("start rose with select low");
  a_quiet_conv: assert property (act_reg && cv_reg && cnt_reg < 9'h10E |-> !sclk_pin)
    else $error("serial clock during conversion");
  a_nobusy_start: assert property (act_reg && cv_reg && mode_reg == 2'b00 && cnt_reg >= 9'h064 && cnt_reg <= 9'h10E |-> conversion_start_pin)
    else $error("start low near conversion end");
  a_busy_start: assert property (act_reg && cv_reg && mode_reg == 2'b01 && cnt_reg >= 9'h064 && cnt_reg <= 9'h117 |-> !conversion_start_pin)
    else $error("start high near conversion end");
  a_four_start: assert property (act_reg && cv_reg && mode_reg[1] |-> conversion_start_pin)
    else $error("start fell in four wire frame");
  a_four_select: assert property (act_reg && cv_reg && mode_reg == 2'b10 && cnt_reg >= 9'h064 && cnt_reg <= 9'h10E |-> serial_input_pin)
    else $error("select low near conversion end");
  a_three_select: assert property (act_reg && !mode_reg[1] |-> serial_input_pin)
    else $error("select moved in three wire frame");
  a_fall_count: assert property (done |-> total == RESULT_BITS + mode_reg[0])
    else $error("wrong count of clock falls");
  c_three_plain: cover property (done && mode_reg == 2'b00);
  c_three_busy: cover property (done && mode_reg == 2'b01);
  c_four_plain: cover property (done && mode_reg == 2'b10);
  c_four_busy: cover property (done && mode_reg == 2'b11);
endmodule // sarh_host_asserts
bind sarh_host sarh_host_asserts #(.RESULT_BITS(RESULT_BITS)) u_chk
(
  .core_clk             (core_clk),
  .rst                  (rst),
  .start_req            (start_req),
  .start_mode           (start_mode),
  .start_ready          (start_ready),
  .conversion_start_pin (conversion_start_pin),
  .serial_input_pin     (serial_input_pin),
  .sclk_pin             (sclk_pin)
);
`default_nettype wire

// File: verification/sarh_dev_model.sv
// Behavioural model of the converter in chip-select style operation.
`timescale 1ns/10ps
`default_nettype none
module sarh_dev_model
#(
  parameter CONV_NS = 1000
)
(
  input  wire logic        conversion_start_pin,
  input  wire logic        serial_input_pin,
  input  wire logic        sclk_pin,
  input  wire logic [15:0] code,
  output wire logic        serial_output_pin
);
  logic [15:0] shift_reg = 16'h0000;
  logic        out_en    = 1'b0;
  logic        out_bit   = 1'b0;
  logic        busy_mode = 1'b0;
  logic        awake     = 1'b0;
  logic        armed     = 1'b0;
  int          falls     = 0;
  wire logic   cs_n;
  assign cs_n = conversion_start_pin & serial_input_pin;
  // A released line shows the inverse of the last bit, so a stale level never passes.
  assign serial_output_pin = out_en ? out_bit : ~out_bit;
  // The power-up rise of the start pin from unknown is not a conversion request.
  always @(negedge conversion_start_pin)
    armed = 1'b1;
  always @(posedge conversion_start_pin)
  begin
    if (serial_input_pin && armed)
    begin
      shift_reg = code;
      out_en    = 1'b0;
      awake     = 1'b1;
      #(CONV_NS);
      awake     = 1'b0;
      falls     = 0;
      busy_mode = ~cs_n;
      out_bit   = 1'b0;
      out_en    = ~cs_n;
    end
  end
  always @(negedge cs_n)
  begin
    if (!awake && !out_en)
    begin
      out_bit = shift_reg[15];
      out_en  = 1'b1;
      falls   = 0;
    end
  end
  always @(posedge cs_n)
  begin
    out_en    = 1'b0;
    busy_mode = 1'b0;
  end
  always @(negedge sclk_pin)
  begin
    if (out_en)
    begin
      falls = falls + 1;
      if (falls == 16 + busy_mode)
        out_en = 1'b0;
      else
        out_bit = shift_reg[15 - falls + busy_mode];
    end
  end
endmodule // sarh_dev_model
`default_nettype wire

// File: verification/sarh_host_tb_top.sv
// Self-checking bench of the converter host.
`timescale 1ns/10ps
`default_nettype none
module sarh_host_tb_top;
  logic        core_clk     = 1'b0;
  logic        rst          = 1'b1;
  logic        start_req    = 1'b0;
  logic [1:0]  start_mode   = 2'h0;
  logic        result_ready = 1'b0;
  logic [15:0] dev_code     = 16'h0000;
  wire logic        start_ready;
  wire logic [15:0] result_data;
  wire logic        result_valid;
  wire logic        busy_seen;
  wire logic        conversion_start_pin;
  wire logic        serial_input_pin;
  wire logic        sclk_pin;
  wire logic        serial_output_pin;
  int err_count = 0;
  int checks    = 0;
  sarh_host dut
  (
    .core_clk             (core_clk),
    .rst                  (rst),
    .start_req            (start_req),
    .start_mode           (start_mode),
    .start_ready          (start_ready),
    .result_data          (result_data),
    .result_valid         (result_valid),
    .result_ready         (result_ready),
    .busy_seen_reg        (busy_seen),
    .conversion_start_pin (conversion_start_pin),
    .serial_input_pin     (serial_input_pin),
    .sclk_pin             (sclk_pin),
    .serial_output_pin    (serial_output_pin)
  );
  sarh_dev_model u_dev
  (
    .conversion_start_pin (conversion_start_pin),
    .serial_input_pin     (serial_input_pin),
    .sclk_pin             (sclk_pin),
    .code                 (dev_code),
    .serial_output_pin    (serial_output_pin)
  );
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %b seen %b", what, exp, got);
      err_count++;
    end
  endtask
  task automatic cmp_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic hang(input string what);
    $display("FAIL %s expected event seen timeout", what);
    err_count++;
    give_verdict();
  endtask
  // Waits at falling edges for one pin level, with a bound.
  task automatic wait_sel(input logic lvl);
    int n;
    for (n = 0; n < 6000 && serial_input_pin !== lvl; n++)
      @(negedge core_clk);
    if (n == 6000)
      hang("serial_input_pin");
  endtask
  task automatic request(input logic [1:0] mode, input logic [15:0] code);
    int n;
    for (n = 0; n < 6000 && start_ready !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 6000)
      hang("start_ready");
    dev_code   = code;
    start_mode = mode;
    start_req  = 1'b1;
    @(negedge core_clk);
    start_req  = 1'b0;
  endtask
  task automatic pop(input logic [15:0] exp);
    int n;
    for (n = 0; n < 6000 && result_valid !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 6000)
      hang("result_valid");
    cmp_word("result_data", exp, result_data);
    result_ready = 1'b1;
    @(negedge core_clk);
    result_ready = 1'b0;
  endtask
  task automatic run_one(input logic [1:0] mode, input logic [15:0] code);
    request(mode, code);
    pop(code);
    cmp_bit("busy_seen", mode[0], busy_seen);
    repeat (400) @(negedge core_clk);
  endtask
  task automatic t_idle();
    cmp_bit("conversion_start_pin", 1'b1, conversion_start_pin);
    cmp_bit("serial_input_pin", 1'b1, serial_input_pin);
    cmp_bit("sclk_pin", 1'b0, sclk_pin);
    cmp_bit("start_ready", 1'b1, start_ready);
    cmp_bit("result_valid", 1'b0, result_valid);
  endtask
  task automatic t_three_plain();
    run_one(2'b00, 16'hFFFF);
    run_one(2'b00, 16'h0000);
  endtask
  task automatic t_three_busy();
    run_one(2'b01, 16'h8000);
  endtask
  task automatic t_four_plain();
    run_one(2'b10, 16'h7FFF);
  endtask
  task automatic t_four_busy();
    run_one(2'b11, 16'h5A3C);
  endtask
  task automatic t_fifo_full();
    int  i;
    logic moved;
    moved = 1'b0;
    for (i = 0; i < 8; i++)
      request(2'b10, 16'h1357 + 16'h1111 * i[15:0]);
    wait_sel(1'b0);
    wait_sel(1'b1);
    repeat (4) @(negedge core_clk);
    start_req = 1'b1;
    repeat (300)
    begin
      @(negedge core_clk);
      moved = moved | ~conversion_start_pin;
    end
    cmp_bit("start_ready", 1'b0, start_ready);
    cmp_bit("refused start", 1'b0, moved);
    start_req = 1'b0;
    for (i = 0; i < 8; i++)
      pop(16'h1357 + 16'h1111 * i[15:0]);
    cmp_bit("result_valid", 1'b0, result_valid);
  endtask
  initial
  begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    t_idle();
    t_three_plain();
    t_three_busy();
    t_four_plain();
    t_four_busy();
    t_fifo_full();
    give_verdict();
  end
endmodule // sarh_host_tb_top
`default_nettype wire
